// *** reset_clock_pkg.sv ***
// constants, types and register map for the reset and clock sequencer
package reset_clock_pkg;

  // register byte addresses on the 16-bit register port
  localparam logic [15:0] ADDR_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] ADDR_RESET_CAUSE  = 16'hFE01;
  localparam logic [15:0] ADDR_BREAK_CLEAR  = 16'hFE03;
  localparam logic [15:0] ADDR_SYS_CONFIG   = 16'hFE04;

  // reset cause bit positions
  localparam int CAUSE_POWER_ON = 7;
  localparam int CAUSE_PIN      = 6;
  localparam int CAUSE_WDOG     = 5;
  localparam int CAUSE_BAD_OP   = 4;
  localparam int CAUSE_BAD_ADDR = 3;
  localparam int CAUSE_BROWNOUT = 1;

  // break registers
  localparam int BREAK_WAIT_BIT  = 1;
  localparam int CLEAR_ALLOW_BIT = 7;

  // system configuration bits
  localparam int CFG_WDOG_DIS   = 0;
  localparam int CFG_BO_PWR_DIS = 1;
  localparam int CFG_BO_RST_DIS = 2;
  localparam int CFG_SHORT_REC  = 3;
  localparam int CFG_STOP_ALLOW = 4;
  localparam int CFG_PLL_SEL    = 5;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // sequence lengths in reference clock ticks
  localparam int STAB_WIDTH      = 12;
  localparam int STAB_TICKS      = 4096;
  localparam int PIN_DRIVE_TICKS = 32;
  localparam int INTERNAL_RESET_LINE_HOLD_TICKS = 32;
  localparam int STOP_SHORT_TICKS = 32;
  localparam int PIN_FLAG_EXTRA  = 3;
  localparam int SEQ_WIDTH       = 13;

  // reset vector addresses
  localparam logic [15:0] VECTOR_NORMAL  = 16'hFFFE;
  localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;

  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_POR_HOLD = 3'b001,
    ST_PIN_DRV  = 3'b010,
    ST_INTERNAL_RESET_LINE     = 3'b011,
    ST_EXT      = 3'b100,
    ST_STOP     = 3'b101,
    ST_STOP_REC = 3'b110
  } state_t;

  // cpu status strobes, same clock domain
  typedef struct packed {
    logic illegalOp;
    logic stopInstr;
    logic waitInstr;
    logic opcodeFetch;
    logic addrUnmapped;
    logic wakeEvent;
    logic breakWait;
    logic monitorMode;
  } cpu_status_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic clockgenTick;
    logic busTick;
    logic cpuClkEn;
    logic periphClkEn;
  } clock_ctl_t;

endpackage

// *** reset_clock_sequencer.sv ***
// bus clock gating and reset sequencing for the system integration unit
//
// Decided for this implementation: the strobed register port.
module reset_clock_sequencer
  import reset_clock_pkg::*;
#(
  parameter int STAB_COUNT = STAB_TICKS  // shorten for simulation
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // reference and pll enable pulses
  input  wire logic        oscRefFall,
  input  wire logic        pllOutTick,
  // asynchronous requests
  input  wire logic        powerOnPulse,
  input  wire logic        brownoutDetector,
  input  wire logic        watchdogReset,
  // cpu status
  input  wire cpu_status_t cpuStat,
  // register port
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // reset pin, open drain
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe_b,
  // outputs to the chip
  output clock_ctl_t       clkCtl,
  output logic             internalResetLine,
  output logic      [15:0] resetVector,
  output logic             watchdogTick,
  output logic             clockgenEnable
);

  localparam logic [SEQ_WIDTH-1:0] STAB_LAST = SEQ_WIDTH'(STAB_COUNT - 1);
  localparam logic [SEQ_WIDTH-1:0] DRV_LAST = SEQ_WIDTH'(PIN_DRIVE_TICKS - 1);
  localparam logic [SEQ_WIDTH-1:0] INTERNAL_RESET_LINE_LAST = SEQ_WIDTH'(INTERNAL_RESET_LINE_HOLD_TICKS - 1);
  localparam logic [SEQ_WIDTH-1:0] SHORT_LAST =
    SEQ_WIDTH'(STOP_SHORT_TICKS - 1);
  localparam logic [SEQ_WIDTH-1:0] PIN_MIN_SHORT =
    SEQ_WIDTH'(PIN_DRIVE_TICKS + INTERNAL_RESET_LINE_HOLD_TICKS + PIN_FLAG_EXTRA);
  localparam logic [SEQ_WIDTH-1:0] PIN_MIN_LONG =
    SEQ_WIDTH'(STAB_COUNT + PIN_DRIVE_TICKS + INTERNAL_RESET_LINE_HOLD_TICKS
               + PIN_FLAG_EXTRA);

  state_t                 state_r;       // sequencer state
  logic [SEQ_WIDTH-1:0]   seqCnt_r;      // ticks spent in current state
  logic [STAB_WIDTH-1:0]  stabCnt_r;     // free stabilisation counter
  logic [SEQ_WIDTH-1:0]   pinLowCnt_r;   // ticks pin seen low
  logic [7:0]             cause_r;       // reset cause flags
  logic [7:0]             config_r;      // system configuration
  logic                   breakWait_r;   // break during wait flag
  logic                   clearAllow_r;  // break flag clear allow
  logic                   waitMode_r;    // cpu in wait
  logic                   srcDiv_r;      // source halving phase
  logic                   busDiv_r;      // clockgen halving phase
  logic                   longCause_r;   // power-on or brownout sequence
  logic [3:0]             syncA_r;       // first synchroniser stage
  logic [3:0]             syncB_r;       // second synchroniser stage
  logic [1:0]             drvEcho_r;     // own pin drive, two flops late
  logic                   pinExt;        // pin held low from outside
  logic                   porS;
  logic                   boS;
  logic                   wdS;
  logic                   pinLowS;
  logic                   srcTick;
  logic                   cgTick;
  logic                   driving;
  logic                   inReset;
  logic                   boReq;
  logic                   wdReq;
  logic                   opReq;
  logic                   adReq;
  logic                   shortReq;
  logic                   pinLimit;
  logic [7:0]             causeMask;

  // two flops on every asynchronous input
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      syncA_r <= 4'h0;
      syncB_r <= 4'h0;
      drvEcho_r <= 2'h3;  // pin is driven while held in reset
    end
    else
    begin
      syncA_r <= {~resetPinIn, watchdogReset, brownoutDetector, powerOnPulse};
      syncB_r <= syncA_r;
      drvEcho_r <= {drvEcho_r[0], driving};
    end
  end

  assign porS    = syncB_r[0];
  assign boS     = syncB_r[1];
  assign wdS     = syncB_r[2];
  assign pinLowS = syncB_r[3];

  // own drive reaches the synced pin two cycles late; mask that echo so
  // letting go of the pin is not taken for an outside pull
  assign pinExt = pinLowS && !driving && !drvEcho_r[1];

  // reset request decode from each source
  assign boReq = boS & ~config_r[CFG_BO_PWR_DIS]
               & ~config_r[CFG_BO_RST_DIS];
  assign wdReq = wdS & ~config_r[CFG_WDOG_DIS];
  assign opReq = cpuStat.illegalOp
               | (cpuStat.stopInstr & ~config_r[CFG_STOP_ALLOW]);
  assign adReq = cpuStat.opcodeFetch & cpuStat.addrUnmapped;
  assign shortReq = wdReq | opReq | adReq;

  assign driving = (state_r == ST_POR_HOLD) || (state_r == ST_PIN_DRV);
  assign inReset = driving || (state_r == ST_INTERNAL_RESET_LINE) || (state_r == ST_EXT);

  // cause bits for a new event, power-on alone wins
  always_comb
  begin
    causeMask = BYTE_ZERO;
    if (porS)
      causeMask[CAUSE_POWER_ON] = 1'b1;
    else
    begin
      causeMask[CAUSE_BROWNOUT] = boReq;
      causeMask[CAUSE_WDOG]     = wdReq;
      causeMask[CAUSE_BAD_OP]   = opReq;
      causeMask[CAUSE_BAD_ADDR] = adReq;
    end
  end

  // clock divider: source over two is clockgen, clockgen over two is bus
  assign srcTick = config_r[CFG_PLL_SEL] ? pllOutTick : oscRefFall;
  assign cgTick  = srcTick & srcDiv_r & clockgenEnable;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      srcDiv_r <= 1'b0;
      busDiv_r <= 1'b0;
    end
    else
    begin
      if (srcTick)
        srcDiv_r <= ~srcDiv_r;
      if (cgTick)
        busDiv_r <= ~busDiv_r;
    end
  end

  // gated enables; cpu stops in wait, peripherals keep running
  always_comb
  begin
    clkCtl.clockgenTick = cgTick;
    clkCtl.busTick      = cgTick & busDiv_r;
    clkCtl.periphClkEn  = clkCtl.busTick && (state_r != ST_POR_HOLD)
                          && (state_r != ST_STOP)
                          && (state_r != ST_STOP_REC);
    clkCtl.cpuClkEn     = clkCtl.periphClkEn && !waitMode_r;
  end

  // clockgen output comes on at power-on and stays on
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      clockgenEnable <= 1'b0;
    else if (porS)
      clockgenEnable <= 1'b1;
  end

  // stabilisation counter, overflow drives watchdog prescale
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      stabCnt_r    <= '0;
      watchdogTick <= 1'b0;
    end
    else if (porS || boReq || shortReq
             || (state_r == ST_RUN && cpuStat.stopInstr))
    begin
      stabCnt_r    <= '0;
      watchdogTick <= 1'b0;
    end
    else
    begin
      watchdogTick <= oscRefFall && (&stabCnt_r);
      if (oscRefFall)
        stabCnt_r <= stabCnt_r + 1'b1;
    end
  end

  // sequencer state and tick count
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_r     <= ST_POR_HOLD;
      seqCnt_r    <= '0;
      longCause_r <= 1'b1;
    end
    else if (porS || boS && boReq)
    begin
      state_r     <= ST_POR_HOLD;
      seqCnt_r    <= '0;
      longCause_r <= 1'b1;
    end
    else if (shortReq && !inReset)
    begin
      state_r     <= ST_PIN_DRV;
      seqCnt_r    <= '0;
      longCause_r <= 1'b0;
    end
    else if (pinExt && state_r != ST_EXT)
    begin
      state_r  <= ST_EXT;
      seqCnt_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_POR_HOLD:
          if (oscRefFall)
          begin
            if (seqCnt_r == STAB_LAST)
            begin
              state_r  <= ST_PIN_DRV;
              seqCnt_r <= '0;
            end
            else
              seqCnt_r <= seqCnt_r + 1'b1;
          end
        ST_PIN_DRV:
          if (oscRefFall)
          begin
            if (seqCnt_r == DRV_LAST)
            begin
              state_r  <= ST_INTERNAL_RESET_LINE;
              seqCnt_r <= '0;
            end
            else
              seqCnt_r <= seqCnt_r + 1'b1;
          end
        ST_INTERNAL_RESET_LINE:
          if (oscRefFall)
          begin
            if (seqCnt_r == INTERNAL_RESET_LINE_LAST)
            begin
              state_r     <= ST_RUN;
              seqCnt_r    <= '0;
              longCause_r <= 1'b0;
            end
            else
              seqCnt_r <= seqCnt_r + 1'b1;
          end
        ST_EXT:
          // release runs the same internal hold as other sources
          if (!pinLowS)
          begin
            state_r  <= ST_INTERNAL_RESET_LINE;
            seqCnt_r <= '0;
          end
        ST_RUN:
          if (cpuStat.stopInstr)
          begin
            state_r  <= ST_STOP;
            seqCnt_r <= '0;
          end
        ST_STOP:
          if (cpuStat.wakeEvent)
          begin
            state_r  <= ST_STOP_REC;
            seqCnt_r <= '0;
          end
        ST_STOP_REC:
          if (oscRefFall)
          begin
            if (seqCnt_r == (config_r[CFG_SHORT_REC] ? SHORT_LAST
                                                     : STAB_LAST))
            begin
              state_r  <= ST_RUN;
              seqCnt_r <= '0;
            end
            else
              seqCnt_r <= seqCnt_r + 1'b1;
          end
        default:
          state_r <= ST_POR_HOLD;
      endcase
    end
  end

  // wait mode flag, left on wake or any reset
  always_ff @(posedge clock)
  begin
    if (!rst_b || inReset || cpuStat.wakeEvent)
      waitMode_r <= 1'b0;
    else if (cpuStat.waitInstr && state_r == ST_RUN)
      waitMode_r <= 1'b1;
  end

  // pin low time, threshold depends on the running sequence
  assign pinLimit = pinLowCnt_r == (longCause_r ? PIN_MIN_LONG
                                                : PIN_MIN_SHORT);

  always_ff @(posedge clock)
  begin
    if (!rst_b || !pinLowS)
      pinLowCnt_r <= '0;
    else if (oscRefFall && !pinLimit)
      pinLowCnt_r <= pinLowCnt_r + 1'b1;
  end

  // cause flags; a new event replaces old flags, later ones add
  // to them, writes never touch it
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      cause_r <= CAUSE_RESET;
    else if (porS)
      cause_r <= causeMask;
    else if (causeMask != BYTE_ZERO && !inReset)
      cause_r <= causeMask;
    else if (pinExt && !inReset)
      cause_r <= BYTE_ZERO;  // fresh pin event
    else
    begin
      cause_r                <= cause_r | causeMask;
      cause_r[CAUSE_PIN]     <= cause_r[CAUSE_PIN] | pinLimit;
    end
  end

  // software registers, all back to defaults under internal reset
  always_ff @(posedge clock)
  begin
    if (!rst_b || inReset)
    begin
      config_r     <= CFG_RESET;
      clearAllow_r <= 1'b0;
    end
    else if (regWrite && regAddr == ADDR_SYS_CONFIG)
      config_r <= regWdata;
    else if (regWrite && regAddr == ADDR_BREAK_CLEAR)
      clearAllow_r <= regWdata[CLEAR_ALLOW_BIT];
  end

  // break wait flag: set wins over a software clear by zero
  always_ff @(posedge clock)
  begin
    if (!rst_b || inReset)
      breakWait_r <= 1'b0;
    else if (cpuStat.breakWait && waitMode_r)
      breakWait_r <= 1'b1;
    else if (regWrite && regAddr == ADDR_BREAK_STATUS
             && !regWdata[BREAK_WAIT_BIT])
      breakWait_r <= 1'b0;
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      regRdata <= BYTE_ZERO;
    else if (!regRead)
      regRdata <= BYTE_ZERO;
    else
    begin
      case (regAddr)
        ADDR_BREAK_STATUS:
          regRdata <= {6'h00, breakWait_r, 1'b0};
        ADDR_RESET_CAUSE:
          regRdata <= cause_r;
        ADDR_BREAK_CLEAR:
          regRdata <= {clearAllow_r, 7'h00};
        ADDR_SYS_CONFIG:
          regRdata <= config_r;
        default:
          regRdata <= BYTE_ZERO;
      endcase
    end
  end

  // pin drive, internal reset and vector
  assign resetPinOut       = 1'b0;
  assign resetPinOe_b      = ~driving;
  assign internalResetLine = inReset;
  assign resetVector = cpuStat.monitorMode ? VECTOR_MONITOR
                                           : VECTOR_NORMAL;

  // checks
  a_pin_drive_len: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_PIN_DRV && seqCnt_r == DRV_LAST && oscRefFall
    && !porS && !boReq
    |=> state_r == ST_INTERNAL_RESET_LINE && !resetPinOe_b == 1'b0)
    else $error("pin drive did not end after its count");
  a_internal_reset_line_release: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_INTERNAL_RESET_LINE && seqCnt_r == INTERNAL_RESET_LINE_LAST && oscRefFall
    && !porS && !boReq && !shortReq && !pinLowS
    |=> !internalResetLine)
    else $error("internal reset not released after hold");
  a_por_hold_pin: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_POR_HOLD |-> !resetPinOe_b && !clkCtl.periphClkEn)
    else $error("pin or clocks wrong during stabilisation");
  a_wait_cpu_off: assert property (@(posedge clock) disable iff (!rst_b)
    waitMode_r |-> !clkCtl.cpuClkEn)
    else $error("cpu clock ran in wait");
  a_bus_quarter: assert property (@(posedge clock) disable iff (!rst_b)
    clkCtl.busTick |=> !clkCtl.busTick)
    else $error("bus tick on consecutive cycles");
  a_wdog_cause: assert property (@(posedge clock) disable iff (!rst_b)
    wdS && !config_r[CFG_WDOG_DIS] && !inReset && !porS
    |=> cause_r[CAUSE_WDOG] && state_r == ST_PIN_DRV)
    else $error("watchdog reset not recorded");
  a_bad_op_cause: assert property (@(posedge clock) disable iff (!rst_b)
    opReq && !inReset && !porS |=> cause_r[CAUSE_BAD_OP])
    else $error("bad opcode not recorded");
  a_data_fetch_ok: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_RUN && cpuStat.addrUnmapped && !cpuStat.opcodeFetch
    && !wdReq && !opReq && !boS && !porS && !pinLowS
    |=> state_r != ST_PIN_DRV)
    else $error("data fetch caused a reset");
  a_cause_ro: assert property (@(posedge clock) disable iff (!rst_b)
    regWrite && regAddr == ADDR_RESET_CAUSE && causeMask == BYTE_ZERO
    && !pinLimit && !pinLowS |=> $stable(cause_r))
    else $error("write changed cause register");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
    cause_r[2] == 1'b0 && cause_r[0] == 1'b0)
    else $error("reserved cause bit set");

  c_por_done: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_INTERNAL_RESET_LINE ##1 state_r == ST_RUN);
  c_stop_exit: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == ST_STOP_REC ##1 state_r == ST_RUN);
  c_pin_flag: cover property (@(posedge clock) disable iff (!rst_b)
    $rose(cause_r[CAUSE_PIN]));
  c_wdog_reset: cover property (@(posedge clock) disable iff (!rst_b)
    $rose(cause_r[CAUSE_WDOG]));

endmodule

// *** reset_board_model.sv ***
// board side of the reset pin: pull-up, device drive, peripheral pull
module reset_board_model (
  // clock and reference ticks
  input  wire logic        clock,
  input  wire logic        oscRefFall,
  // pull request from the bench
  input  wire logic        startPull,
  input  wire logic [15:0] pullTicks,
  // device side of the open-drain pin
  input  wire logic        resetPinOut,
  input  wire logic        resetPinOe_b,
  // resolved pin level
  output logic             pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] pullCnt_r = 16'h0000;  // ticks left of external pull

  // external pull counted in reference ticks
  always_ff @(posedge clock)
  begin
    if (startPull)
      pullCnt_r <= pullTicks;
    else if (oscRefFall && pullCnt_r != 16'h0000)
      pullCnt_r <= pullCnt_r - 16'h0001;
  end

  // wired-and with pull-up: any party pulling low wins
  assign pinLevel = !((pullCnt_r != 16'h0000) ||
                      (!resetPinOe_b && !resetPinOut));
endmodule

// *** tb_top.sv ***
// self-checking bench for the reset and clock sequencer
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin errCount++; \
  $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  import reset_clock_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int STAB = 64;  // shortened stabilisation count

  // design stimulus
  logic        clock, rst_b;
  logic        oscRefFall = 1'b0;  // driven only by the tick process
  logic        pllOutTick = 1'b0;
  logic        powerOnPulse, brownoutDetector, watchdogReset;
  cpu_status_t cpuStat;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata;
  logic        regWrite, regRead, pinLevel, resetPinOut, resetPinOe_b;
  clock_ctl_t  clkCtl;
  logic        internalResetLine, watchdogTick, clockgenEnable;
  logic [15:0] resetVector, pullTicks;
  logic        startPull;
  logic [1:0]  refDiv = 2'h0;   // reference tick every fourth cycle
  logic [1:0]  pllDiv = 2'h0;   // pll tick every third cycle
  int          errCount, testsRun;

  reset_clock_sequencer #(.STAB_COUNT(STAB)) reset_clock_sequencer_i (
    .clock(clock), .rst_b(rst_b), .oscRefFall(oscRefFall),
    .pllOutTick(pllOutTick), .powerOnPulse(powerOnPulse),
    .brownoutDetector(brownoutDetector), .watchdogReset(watchdogReset),
    .cpuStat(cpuStat), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .resetPinIn(pinLevel), .resetPinOut(resetPinOut),
    .resetPinOe_b(resetPinOe_b), .clkCtl(clkCtl),
    .internalResetLine(internalResetLine), .resetVector(resetVector),
    .watchdogTick(watchdogTick), .clockgenEnable(clockgenEnable));

  reset_board_model reset_board_model_i (
    .clock(clock), .oscRefFall(oscRefFall), .startPull(startPull),
    .pullTicks(pullTicks), .resetPinOut(resetPinOut),
    .resetPinOe_b(resetPinOe_b), .pinLevel(pinLevel));

  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // reference and pll tick pulses at different rates
  always @(posedge clock)
  begin
    refDiv <= refDiv + 2'd1;
    oscRefFall <= (refDiv == 2'd3);
    pllDiv <= (pllDiv == 2'd2) ? 2'd0 : pllDiv + 2'd1;
    pllOutTick <= (pllDiv == 2'd2);
  end

  // tolerance check for counts whose phase is loose
  function automatic logic near(int a, int b, int t);
    return (a >= b - t) && (a <= b + t);
  endfunction

  // one-hot byte for a cause or config bit
  function automatic logic [7:0] bitv(int n);
    return 8'h01 << n;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic pulse_cpu(input cpu_status_t s);
    @(posedge clock);
    cpuStat <= s;
    @(posedge clock);
    cpuStat <= '0;
  endtask

  // async requests held long enough for the two-flop sync
  task automatic hold4();
    repeat (4) @(posedge clock);
  endtask

  // follows one reset sequence, counting driven and held ticks
  task automatic run_reset(input logic [7:0] cause, input int pin,
                           input int hold, input int tol);
    int i, p, h;
    logic [7:0] d;
    i = 0;
    p = 0;
    h = 0;
    while (internalResetLine !== 1'b1 && i < 20)
    begin
      @(posedge clock);
      #1 i++;
    end
    `CHK(internalResetLine, 1'b1)
    `CHK(resetVector, VECTOR_NORMAL)
    i = 0;
    while (internalResetLine === 1'b1 && i < 40000)
    begin
      @(posedge clock);
      #1 i++;
      if (oscRefFall === 1'b1 && resetPinOe_b === 1'b0)
        p++;  // device pulling the pin
      else if (oscRefFall === 1'b1)
        h++;  // internal reset only
    end
    `CHK(near(p, pin, tol), 1'b1)
    `CHK(near(h, hold, tol), 1'b1)
    rd(ADDR_RESET_CAUSE, d);
    `CHK(d, cause)
  endtask

  task automatic no_reset();
    logic seen;
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clock);
      #1 if (internalResetLine !== 1'b0) seen = 1'b1;
    end
    `CHK(seen, 1'b0)
  endtask

  // power-up: hold, drive, release, clockgen on, only power bit
  task automatic t_power_on();
    @(posedge clock);
    powerOnPulse <= 1'b1;
    hold4();
    powerOnPulse <= 1'b0;
    run_reset(bitv(CAUSE_POWER_ON), STAB + 32, 32, 3);
    `CHK(clockgenEnable, 1'b1)
  endtask

  // defaults, read-only cause, unmapped, vector select
  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_SYS_CONFIG, d);
    `CHK(d, CFG_RESET)
    wr(ADDR_RESET_CAUSE, 8'hFF);
    rd(ADDR_RESET_CAUSE, d);
    `CHK(d, bitv(CAUSE_POWER_ON))
    @(posedge clock);
    #1 `CHK(regRdata, BYTE_ZERO)
    wr(ADDR_BREAK_CLEAR, 8'h80);
    rd(ADDR_BREAK_CLEAR, d);
    `CHK(d, bitv(CLEAR_ALLOW_BIT))
    rd(16'h1234, d);
    `CHK(d, BYTE_ZERO)
    @(posedge clock);
    cpuStat <= '{monitorMode: 1'b1, default: 1'b0};
    @(posedge clock);
    #1 `CHK(resetVector, VECTOR_MONITOR)
    cpuStat <= '0;
  endtask

  // bus and clockgen ticks over 64 source ticks, both sources
  task automatic t_bus_ratio();
    int b, g, s;
    for (int sel = 0; sel < 2; sel++)
    begin
      wr(ADDR_SYS_CONFIG, sel[0] ? bitv(CFG_PLL_SEL) : 8'h00);
      b = 0;
      g = 0;
      s = 0;
      while (s < 64)
      begin
        @(posedge clock);
        #1 if ((sel[0] ? pllOutTick : oscRefFall) === 1'b1) s++;
        if ((sel[0] ? pllOutTick : oscRefFall) === 1'b1)
        begin
          b += (clkCtl.busTick === 1'b1);
          g += (clkCtl.clockgenTick === 1'b1);
        end
      end
      `CHK(b, 16)
      `CHK(g, 32)
    end
    wr(ADDR_SYS_CONFIG, 8'h00);
  endtask

  // wait stops cpu clock only, wake brings it back
  task automatic t_wait();
    int c, p;
    c = 0;
    p = 0;
    pulse_cpu('{waitInstr: 1'b1, default: 1'b0});
    repeat (60)
    begin
      @(posedge clock);
      #1 c += (clkCtl.cpuClkEn === 1'b1);
      p += (clkCtl.periphClkEn === 1'b1);
    end
    `CHK(c, 0)
    `CHK(p > 0, 1'b1)
    pulse_cpu('{wakeEvent: 1'b1, default: 1'b0});
    c = 0;
    repeat (60)
    begin
      @(posedge clock);
      #1 c += (clkCtl.cpuClkEn === 1'b1);
    end
    `CHK(c > 0, 1'b1)
  endtask

  // stop exit delay, short and long recovery
  task automatic t_stop();
    int n, i;
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_SYS_CONFIG, bitv(CFG_STOP_ALLOW) | (k ? 8'h00 : 8'h08));
      pulse_cpu('{stopInstr: 1'b1, default: 1'b0});
      repeat (8) @(posedge clock);
      pulse_cpu('{wakeEvent: 1'b1, default: 1'b0});
      n = 0;
      i = 0;
      while (clkCtl.cpuClkEn !== 1'b1 && i < 2000)
      begin
        @(posedge clock);
        #1 i++;
        n += (oscRefFall === 1'b1);
      end
      `CHK(near(n, k ? STAB : STOP_SHORT_TICKS, 5), 1'b1)
      `CHK(internalResetLine, 1'b0)
    end
    wr(ADDR_SYS_CONFIG, 8'h00);
  endtask

  // illegal opcode and disallowed stop
  task automatic t_opcode();
    pulse_cpu('{illegalOp: 1'b1, default: 1'b0});
    run_reset(bitv(CAUSE_BAD_OP), 32, 32, 2);
    pulse_cpu('{stopInstr: 1'b1, default: 1'b0});
    run_reset(bitv(CAUSE_BAD_OP), 32, 32, 2);
  endtask

  // data fetch from a hole is harmless, opcode fetch resets
  task automatic t_address();
    logic [7:0] d;
    wr(ADDR_SYS_CONFIG, bitv(CFG_PLL_SEL));
    pulse_cpu('{addrUnmapped: 1'b1, default: 1'b0});
    no_reset();
    pulse_cpu('{opcodeFetch: 1'b1, addrUnmapped: 1'b1, default: 1'b0});
    run_reset(bitv(CAUSE_BAD_ADDR), 32, 32, 2);
    rd(ADDR_SYS_CONFIG, d);
    `CHK(d, CFG_RESET)
    rd(ADDR_BREAK_CLEAR, d);
    `CHK(d, BYTE_ZERO)
  endtask

  // watchdog request through the synchroniser, then disabled
  task automatic t_watchdog();
    @(posedge clock);
    watchdogReset <= 1'b1;
    hold4();
    watchdogReset <= 1'b0;
    run_reset(bitv(CAUSE_WDOG), 32, 32, 2);
    wr(ADDR_SYS_CONFIG, bitv(CFG_WDOG_DIS));
    watchdogReset <= 1'b1;
    hold4();
    watchdogReset <= 1'b0;
    no_reset();
  endtask

  // brownout with either disable bit set, then enabled
  task automatic t_brownout();
    for (int k = CFG_BO_PWR_DIS; k <= CFG_BO_RST_DIS; k++)
    begin
      wr(ADDR_SYS_CONFIG, bitv(k));
      brownoutDetector <= 1'b1;
      hold4();
      brownoutDetector <= 1'b0;
      no_reset();
    end
    wr(ADDR_SYS_CONFIG, 8'h00);
    brownoutDetector <= 1'b1;
    hold4();
    brownoutDetector <= 1'b0;
    run_reset(bitv(CAUSE_BROWNOUT), STAB + 32, 32, 3);
  endtask

  // peripheral pulls pin: long pull flags, short pull does not
  task automatic t_pin(input int ticks, input logic [7:0] cause);
    @(posedge clock);
    pullTicks <= 16'(ticks);
    startPull <= 1'b1;
    @(posedge clock);
    startPull <= 1'b0;
    run_reset(cause, 0, ticks + 32, 3);
  endtask

  // counter wraps 4096 ticks after an internal clear, pin pull meanwhile
  task automatic t_wdog_tick();
    int n;
    n = 0;
    pulse_cpu('{illegalOp: 1'b1, default: 1'b0});
    pullTicks <= 16'h0050;
    startPull <= 1'b1;
    while (watchdogTick !== 1'b1 && n < 5000)
    begin
      @(posedge clock);
      startPull <= 1'b0;
      #1 n += (oscRefFall === 1'b1);
    end
    `CHK(near(n, STAB_TICKS, 2), 1'b1)
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", errCount, testsRun);
    if (errCount == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rst_b, powerOnPulse, brownoutDetector, watchdogReset} = 4'h0;
    {regWrite, regRead, startPull} = 3'h0;
    {regAddr, pullTicks} = 32'h0000_0000;
    regWdata = 8'h00;
    cpuStat = '0;
    errCount = 0;
    testsRun = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    t_power_on();
    t_regs();
    t_bus_ratio();
    t_wait();
    t_stop();
    t_opcode();
    t_address();
    t_watchdog();
    t_brownout();
    t_pin(80, bitv(CAUSE_PIN));
    t_pin(20, 8'h00);
    t_wdog_tick();
    end_sim();
  end

  // hang guard, well beyond the expected run of some 20k cycles
  initial
  begin
    #1000000;
    errCount++;
    end_sim();
  end
endmodule
